// >>> logic/swc_pkg.sv
// Purpose: shared constants and crc functions for the single-wire slot and check block
// Assumes: 25 MHz clock, line sampled synchronously
// Notes:   times in ns, cycle counts derived from the clock period
package swc_pkg;

  localparam int CLK_NS = 40;

  // slot timing, standard speed
  localparam int READ_LOW_TIME_NS            = 6000;
  localparam int MASTER_SAMPLE_WINDOW_END_NS = 15000;
  localparam int SLOT_DURATION_NS            = 65000;
  localparam int RISING_EDGE_HOLDOFF_NS      = 2000;
  localparam int START_FILTER_NS             = 200;
  localparam int WRITE_SAMPLE_NS             = 30000;
  localparam int RESET_LOW_NS                = 480000;
  localparam int PRESENCE_WAIT_NS            = 30000;
  localparam int PRESENCE_LOW_NS             = 120000;
  // overdrive timing
  localparam int OD_READ_LOW_TIME_NS         = 1000;
  localparam int OD_SLOT_DURATION_NS         = 10000;
  localparam int OD_MASTER_SAMPLE_END_NS     = 2000;
  localparam int OD_WRITE_SAMPLE_NS          = 3000;
  localparam int OD_RESET_LOW_NS             = 48000;
  localparam int OD_PRESENCE_WAIT_NS         = 2000;
  localparam int OD_PRESENCE_LOW_NS          = 8000;

  // least times round up, longest times round down
  localparam int READ_LOW_CYC    = (READ_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_END_CYC  = MASTER_SAMPLE_WINDOW_END_NS / CLK_NS;
  localparam int SLOT_CYC        = (SLOT_DURATION_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLDOFF_CYC     = RISING_EDGE_HOLDOFF_NS / CLK_NS;
  localparam int FILTER_CYC      = (START_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int WSAMPLE_CYC     = WRITE_SAMPLE_NS / CLK_NS;
  localparam int RESET_LOW_CYC   = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_WAIT_CYC     = PRESENCE_WAIT_NS / CLK_NS;
  localparam int PD_LOW_CYC      = PRESENCE_LOW_NS / CLK_NS;
  localparam int OD_READ_LOW_CYC = (OD_READ_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int OD_SLOT_CYC     = (OD_SLOT_DURATION_NS + CLK_NS - 1) / CLK_NS;
  localparam int OD_SAMPLE_CYC   = OD_MASTER_SAMPLE_END_NS / CLK_NS;
  localparam int OD_WSAMPLE_CYC  = OD_WRITE_SAMPLE_NS / CLK_NS;
  localparam int OD_RESET_CYC    = (OD_RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int OD_PD_WAIT_CYC  = OD_PRESENCE_WAIT_NS / CLK_NS;
  localparam int OD_PD_LOW_CYC   = OD_PRESENCE_LOW_NS / CLK_NS;

  // check polynomials, reflected for lsb-first shifting
  localparam logic [7:0]  CRC8_POLY_REFL  = 8'h8c;
  localparam logic [15:0] CRC16_POLY_REFL = 16'ha001;
  localparam logic [15:0] CRC16_INIT      = 16'h0000;

  // command codes
  localparam logic [7:0] CMD_WRITE_SCRATCH           = 8'h0f;
  localparam logic [7:0] CMD_READ_SCRATCH            = 8'haa;
  localparam logic [7:0] COPY_SCRATCH_PROTECTED_CMD  = 8'h99;
  localparam logic [7:0] READ_MEMORY_CHECKED_CMD     = 8'h69;

  // framing
  localparam int         PASSWORD_BYTES = 8;
  localparam logic [4:0] SCRATCH_END    = 5'h1f;
  localparam logic [7:0] FILL_FAIL      = 8'hff;
  localparam logic [7:0] FILL_COPY_OK   = 8'haa;
  localparam logic [7:0] ID_FAMILY      = 8'h41; // arbitrary value

  // per-bit crc update, lsb first
  function automatic logic [15:0] swc_crc16_bit(input logic [15:0] c, input logic b);
    swc_crc16_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC16_POLY_REFL) : (c >> 1);
  endfunction : swc_crc16_bit

  function automatic logic [7:0] swc_crc8_bit(input logic [7:0] c, input logic b);
    swc_crc8_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC8_POLY_REFL) : (c >> 1);
  endfunction : swc_crc8_bit

endpackage : swc_pkg

// >>> logic/swc_link_if.sv
// Purpose: the shared line between master and device ends
// Assumes: open-drain line with pull-up, resolved from the enables
// Notes:   each end drives low only while its enable is high
`timescale 1ns/10ps
interface swc_link_if;
  logic mst_oe;
  logic dev_oe;
  logic line;

  // wired-and with pull-up
  assign line = ~(mst_oe | dev_oe);

  modport master (output mst_oe, input line);
  modport device (output dev_oe, input line);
endinterface : swc_link_if

// >>> logic/swc_device.sv
// Purpose: device end: slot timing, glitch hold-off, crc and byte framing
// Assumes: line synchronous to clk; speed mode and memory outside this block
// Notes:   scratchpad is 32 bytes held here; memory reads come in on mem_rdata
`timescale 1ns/10ps
// Notes on behaviour
// - zero bit: pull low, release at timer
// - one bit: never pull the line low
// - master opens read slot like write-one
// - master samples in window, waits slot end
// - ignore glitches inside rising-edge hold-off
// - start-edge filter only at standard speed
// - id top byte is crc8 of 56 bits
// - crc16 x16+x15+x2+1 sent inverted
// - first memory pass: cmd, address, data
// - password bytes never enter the crc
// - later memory passes: data bytes only
// - scratch write crc: cmd, address, data
// - write crc only when offset 1f written
// - scratch read crc: cmd, address, status, data
// - read crc only at last scratch byte
// - master sends exactly eight password bytes
// - end-of-scratch run continues to 1f
// - after end or failure send ff forever; after a failed copy password the status byte goes out once first
// - after good copy send aa forever
// - transactions start with reset and presence
// - slot timer starts at falling edge
module swc_device #(
  parameter int PAGE_BYTES = 32
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // link
  swc_link_if.device      link,
  // user side
  input  wire logic       overdrive,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       pw_ok,
  output logic [15:0]     mem_addr_q,
  output logic            copy_done_q,
  output logic [47:0]     id_serial_q,
  output logic [7:0]      id_crc_q
);
  initial if (PAGE_BYTES < 2 || PAGE_BYTES > 256 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0)
    $error("PAGE_BYTES must be a power of two from 2 to 256");

  typedef enum logic [6:0] {
    ST_CMD  = 7'h01, ST_ADDR = 7'h02, ST_PW   = 7'h04, ST_DATA = 7'h08,
    ST_CRC  = 7'h10, ST_ES   = 7'h20, ST_FILL = 7'h40
  } swc_dstate_t;

  logic [2:0]  sync_q;
  logic        line_s;
  logic [15:0] tmr_q;
  logic        active_q, low_q;
  logic [15:0] flt_q, hold_q, rst_cnt_q;
  logic [15:0] pd_q;
  logic        pres_q;
  logic        slot_go;
  swc_dstate_t st_q;
  logic [7:0]  sh_q, tx_q, cmd_q, fill_q;
  logic [2:0]  bit_q;
  logic [3:0]  cnt_q;
  logic [15:0] crc_q;
  logic [4:0]  off_q;
  logic        wrote_end_q, crc_hi_q;
  logic [7:0]  scratch_q [0:31];
  logic        dev_oe_q;
  logic        byte_done;
  logic        rx_bit;
  logic        sending;

  // synchroniser: stage 0 feeds only stage 1
  always_ff @(posedge clk)
  begin
    sync_q <= {sync_q[1:0], link.line};
  end
  assign line_s = sync_q[2];

  // start filter and rising-edge hold-off
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flt_q  <= 16'h0000;
      hold_q <= 16'h0000;
    end
    else
    begin
      flt_q  <= (line_s || active_q) ? 16'h0000 : flt_q + 16'h0001;
      hold_q <= (line_s && low_q) ? 16'(swc_pkg::HOLDOFF_CYC) :
                (hold_q != 16'h0000 ? hold_q - 16'h0001 : 16'h0000);
    end
  end
  // filter only at standard speed; hold-off masks early droops
  assign slot_go = !active_q && !pres_q && !line_s && hold_q == 16'h0000 &&
                   (overdrive || flt_q >= 16'(swc_pkg::FILTER_CYC));

  // slot timer from the falling edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tmr_q    <= 16'h0000;
      active_q <= 1'b0;
      low_q    <= 1'b0;
    end
    else
    begin
      low_q <= !line_s;
      if (slot_go)
      begin
        active_q <= 1'b1;
        tmr_q    <= 16'h0000;
      end
      else if (active_q)
      begin
        tmr_q <= tmr_q + 16'h0001;
        if (line_s && tmr_q >= 16'(overdrive ? swc_pkg::OD_WSAMPLE_CYC : swc_pkg::WSAMPLE_CYC))
          active_q <= 1'b0;
      end
    end
  end

  // presence timing follows the speed in use
  wire [15:0] pdw_c = 16'(overdrive ? swc_pkg::OD_PD_WAIT_CYC : swc_pkg::PD_WAIT_CYC);
  wire [15:0] pdl_c = 16'(overdrive ? swc_pkg::OD_PD_LOW_CYC : swc_pkg::PD_LOW_CYC);

  // bus reset detection and presence pulse; our own presence low is neither reset nor slot
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rst_cnt_q <= 16'h0000;
      pd_q      <= 16'h0000;
      pres_q    <= 1'b0;
    end
    else
    begin
      rst_cnt_q <= (line_s || pres_q) ? 16'h0000 : rst_cnt_q + 16'h0001;
      if (line_s && rst_cnt_q >= 16'(overdrive ? swc_pkg::OD_RESET_CYC : swc_pkg::RESET_LOW_CYC))
      begin
        pd_q   <= pdw_c + pdl_c;
        pres_q <= 1'b1;
      end
      else
      begin
        if (pd_q != 16'h0000)
          pd_q <= pd_q - 16'h0001;
        if (pd_q == 16'h0000 && line_s)
          pres_q <= 1'b0;
      end
    end
  end
  wire bus_reset = line_s && rst_cnt_q >= 16'(overdrive ? swc_pkg::OD_RESET_CYC
                                                     : swc_pkg::RESET_LOW_CYC);

  // write sample point and read bit
  wire samp_pt = active_q && tmr_q == 16'(overdrive ? swc_pkg::OD_WSAMPLE_CYC
                                                 : swc_pkg::WSAMPLE_CYC);
  assign rx_bit    = line_s;
  assign sending   = (st_q == ST_DATA && cmd_q != swc_pkg::CMD_WRITE_SCRATCH) ||
                     st_q == ST_CRC || st_q == ST_FILL ||
                     (st_q == ST_ES && cmd_q == swc_pkg::CMD_READ_SCRATCH);
  assign byte_done = samp_pt && bit_q == 3'd7;
  // the prefetched address wraps a page while the last byte of the page goes out
  wire page_end = (mem_addr_q & 16'(PAGE_BYTES - 1)) == 16'h0000;

  // open-drain drive: zero bits held to the sample end, ones never driven
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dev_oe_q <= 1'b0;
    else if (pd_q != 16'h0000 && pd_q <= pdl_c)
      dev_oe_q <= 1'b1;
    else if (slot_go && sending && !(tx_q[bit_q]))
      dev_oe_q <= 1'b1;
    else if (tmr_q >= 16'(overdrive ? swc_pkg::OD_SAMPLE_CYC : swc_pkg::SAMPLE_END_CYC))
      dev_oe_q <= 1'b0;
  end
  assign link.dev_oe = dev_oe_q;

  // id crc over 48 serial bits and family byte
  always_ff @(posedge clk)
  begin
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++)
      c = swc_pkg::swc_crc8_bit(c, swc_pkg::ID_FAMILY[i]);
    for (int i = 0; i < 48; i++)
      c = swc_pkg::swc_crc8_bit(c, id_serial_q[i]);
    if (sys_rst)
    begin
      id_serial_q <= 48'h0000_0000_0001; // arbitrary value
      id_crc_q    <= 8'h00;
    end
    else
      id_crc_q <= c;
  end

  // byte framing, crc and scratchpad
  always_ff @(posedge clk)
  begin
    logic [7:0]  nb;
    logic [15:0] c;
    nb = {rx_bit, sh_q[7:1]};
    c  = crc_q;
    if (sys_rst || bus_reset)
    begin
      st_q <= ST_CMD; bit_q <= 3'd0; cnt_q <= 4'd0; crc_q <= swc_pkg::CRC16_INIT;
      sh_q <= 8'h00; tx_q <= 8'hff; cmd_q <= 8'h00; fill_q <= swc_pkg::FILL_FAIL;
      off_q <= 5'd0; crc_hi_q <= 1'b0;
      mem_addr_q <= 16'h0000; copy_done_q <= 1'b0;
    end
    else if (samp_pt)
    begin
      bit_q <= bit_q + 3'd1;
      sh_q  <= nb;
      // step the memory address while a byte goes out, so the next one is ready
      if (st_q == ST_DATA && cmd_q == swc_pkg::READ_MEMORY_CHECKED_CMD && bit_q == 3'd0)
        mem_addr_q <= mem_addr_q + 16'h0001;
      // crc sees the bit on the line, lsb first; skipped in password, crc, fill
      if (st_q == ST_CMD || st_q == ST_ADDR || st_q == ST_ES || st_q == ST_DATA)
        crc_q <= swc_pkg::swc_crc16_bit(c, sending ? tx_q[bit_q] : rx_bit);
      if (byte_done)
      begin
        case (st_q)
          ST_CMD:
          begin
            cmd_q <= nb;
            crc_q <= swc_pkg::swc_crc16_bit(c, rx_bit);
            st_q  <= ST_ADDR;
            cnt_q <= 4'd0;
          end
          ST_ADDR:
          begin
            cnt_q <= cnt_q + 4'd1;
            if (cnt_q == 4'd0)
              mem_addr_q[7:0] <= nb;
            else
            begin
              mem_addr_q[15:8] <= nb;
              off_q <= mem_addr_q[4:0];
              cnt_q <= 4'd0;
              if (cmd_q == swc_pkg::READ_MEMORY_CHECKED_CMD)
                st_q <= ST_PW;
              else if (cmd_q == swc_pkg::CMD_WRITE_SCRATCH)
                st_q <= ST_DATA;
              else if (cmd_q == swc_pkg::CMD_READ_SCRATCH || cmd_q == swc_pkg::COPY_SCRATCH_PROTECTED_CMD)
              begin
                st_q <= ST_ES;
                tx_q <= {wrote_end_q, 2'b00, 5'h1f};
              end
              else
                st_q <= ST_FILL;
            end
          end
          ST_ES:
          begin
            if (cmd_q == swc_pkg::COPY_SCRATCH_PROTECTED_CMD)
              st_q <= ST_PW;
            else
            begin
              st_q <= ST_DATA;
              tx_q <= scratch_q[off_q];
            end
          end
          ST_PW:
          begin
            cnt_q <= cnt_q + 4'd1;
            if (cnt_q == 4'(swc_pkg::PASSWORD_BYTES - 1))
            begin
              cnt_q <= 4'd0;
              if (!pw_ok)
                st_q <= ST_FILL;
              else if (cmd_q == swc_pkg::COPY_SCRATCH_PROTECTED_CMD)
              begin
                st_q        <= ST_FILL;
                fill_q      <= swc_pkg::FILL_COPY_OK;
                tx_q        <= swc_pkg::FILL_COPY_OK;
                copy_done_q <= 1'b1;
              end
              else
              begin
                st_q <= ST_DATA;
                tx_q <= mem_rdata;
              end
            end
          end
          ST_DATA:
          begin
            off_q <= off_q + 5'd1;
            if (cmd_q == swc_pkg::CMD_WRITE_SCRATCH)
              scratch_q[off_q] <= nb;
            // memory runs end at the page end, scratch runs at offset 1f
            if ((cmd_q == swc_pkg::READ_MEMORY_CHECKED_CMD) ? page_end :
                (off_q == swc_pkg::SCRATCH_END))
            begin
              if (cmd_q == swc_pkg::CMD_WRITE_SCRATCH)
                wrote_end_q <= 1'b1;
              st_q        <= ST_CRC;
              tx_q        <= ~crc_next_lo(c, sending ? tx_q[7] : rx_bit);
              crc_hi_q    <= 1'b0;
            end
            else if (cmd_q == swc_pkg::READ_MEMORY_CHECKED_CMD)
              tx_q <= mem_rdata;
            else
              tx_q <= scratch_q[off_q + 5'd1];
          end
          ST_CRC:
          begin
            if (!crc_hi_q)
            begin
              crc_hi_q <= 1'b1;
              tx_q     <= ~crc_q[15:8];
            end
            else if (cmd_q == swc_pkg::READ_MEMORY_CHECKED_CMD)
            begin
              st_q    <= ST_DATA;
              crc_q   <= swc_pkg::CRC16_INIT;
              tx_q    <= mem_rdata;
            end
            else
            begin
              st_q <= ST_FILL;
              tx_q <= fill_q;
            end
          end
          ST_FILL:
            tx_q <= fill_q;
          default:
            st_q <= ST_FILL;
        endcase
      end
    end
    // the written-to-end flag outlives bus resets
    if (sys_rst)
      wrote_end_q <= 1'b0;
  end

  // low byte of the crc after the final bit
  function automatic logic [7:0] crc_next_lo(input logic [15:0] c, input logic b);
    logic [15:0] n;
    n = swc_pkg::swc_crc16_bit(c, b);
    crc_next_lo = n[7:0];
  endfunction : crc_next_lo

endmodule : swc_device

// >>> logic/swc_master.sv
// Purpose: master end: reset, presence check, write and read slots
// Assumes: one command per request from the user side
// Notes:   bytes go lsb first; read byte appears with done
`timescale 1ns/10ps
module swc_master (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // link
  swc_link_if.master      link,
  // user side
  input  wire logic       req,
  input  wire logic [1:0] op,
  input  wire logic [7:0] wdata,
  input  wire logic       overdrive,
  output logic            busy_q,
  output logic            done_q,
  output logic [7:0]      rdata_q,
  output logic            presence_q
);
  // op codes: 0 reset, 1 write byte, 2 read byte
  typedef enum logic [2:0] {M_IDLE = 3'h1, M_SLOT = 3'h2, M_RST = 3'h4} swc_mstate_t;

  swc_mstate_t st_q;
  logic [1:0]  sync_q;
  logic [15:0] t_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_q;
  logic [1:0]  op_q;
  logic        oe_q;

  // line synchroniser
  always_ff @(posedge clk)
  begin
    sync_q <= {sync_q[0], link.line};
  end

  wire [15:0] low_c  = (op_q == 2'd2 || sh_q[0]) ?
                       16'(overdrive ? swc_pkg::OD_READ_LOW_CYC : swc_pkg::READ_LOW_CYC) :
                       16'(overdrive ? swc_pkg::OD_WSAMPLE_CYC : swc_pkg::WSAMPLE_CYC) + 16'h0004;
  wire [15:0] samp_c = 16'(overdrive ? swc_pkg::OD_SAMPLE_CYC : swc_pkg::SAMPLE_END_CYC) - 16'h0002;
  wire [15:0] slot_c = 16'(overdrive ? swc_pkg::OD_SLOT_CYC : swc_pkg::SLOT_CYC);
  wire [15:0] rl_c   = 16'(overdrive ? swc_pkg::OD_RESET_CYC : swc_pkg::RESET_LOW_CYC);
  wire [15:0] pdw_c  = 16'(overdrive ? swc_pkg::OD_PD_WAIT_CYC : swc_pkg::PD_WAIT_CYC);

  // slot and reset sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= M_IDLE; t_q <= 16'h0000; bit_q <= 3'd0; sh_q <= 8'h00; op_q <= 2'd0;
      oe_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0; rdata_q <= 8'h00; presence_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      t_q    <= t_q + 16'h0001;
      case (st_q)
        M_IDLE:
          if (req)
          begin
            op_q <= op; sh_q <= wdata; bit_q <= 3'd0; t_q <= 16'h0000;
            busy_q <= 1'b1; oe_q <= 1'b1;
            st_q <= (op == 2'd0) ? M_RST : M_SLOT;
          end
        M_RST:
        begin
          if (t_q == rl_c)
            oe_q <= 1'b0;
          if (t_q == rl_c + pdw_c + 16'h0010)
            presence_q <= !sync_q[1];
          if (t_q == rl_c + rl_c)
          begin
            st_q <= M_IDLE; busy_q <= 1'b0; done_q <= 1'b1;
          end
        end
        M_SLOT:
        begin
          if (t_q == low_c)
            oe_q <= 1'b0;
          if (t_q == samp_c && op_q == 2'd2)
            sh_q <= {sync_q[1], sh_q[7:1]};
          if (t_q == slot_c)
          begin
            t_q   <= 16'h0000;
            bit_q <= bit_q + 3'd1;
            // a write bit moves on only here, so its release time holds for the slot
            if (op_q != 2'd2)
              sh_q <= {sh_q[0], sh_q[7:1]};
            if (bit_q == 3'd7)
            begin
              st_q <= M_IDLE; busy_q <= 1'b0; done_q <= 1'b1; rdata_q <= sh_q;
            end
            else
              oe_q <= 1'b1;
          end
        end
        default:
          st_q <= M_IDLE;
      endcase
    end
  end
  assign link.mst_oe = oe_q;

endmodule : swc_master

// >>> verif/swc_link_monitor.sv
// Purpose: wire-level checks on the line shared by the master and device ends
// Assumes: both ends run at overdrive timing while these checks watch them
// Notes:   sees only the interface signals; helper counters time the pulses
`timescale 1ns/10ps
module swc_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // line
  input wire logic mst_oe,
  input wire logic dev_oe,
  input wire logic line
);
  logic        mst_q;
  logic [15:0] low_c_q;
  logic [15:0] per_c_q;
  logic [15:0] dlow_c_q;
  logic        prst_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // previous master enable, for edge detection
  always_ff @(posedge clk)
    mst_q <= sys_rst ? 1'b0 : mst_oe;

  // length of the current master pulldown
  always_ff @(posedge clk)
    if (sys_rst || !mst_oe) low_c_q <= 16'h0000;
    else if (low_c_q != 16'hffff) low_c_q <= low_c_q + 16'h0001;

  // cycles since the master last started a pulldown
  always_ff @(posedge clk)
    if (sys_rst) per_c_q <= 16'hffff;
    else if (mst_oe && !mst_q) per_c_q <= 16'h0000;
    else if (per_c_q != 16'hffff) per_c_q <= per_c_q + 16'h0001;

  // length of the current device pulldown
  always_ff @(posedge clk)
    if (sys_rst || !dev_oe) dlow_c_q <= 16'h0000;
    else if (dlow_c_q != 16'hffff) dlow_c_q <= dlow_c_q + 16'h0001;

  // set between a bus reset release and the next master slot
  always_ff @(posedge clk)
    if (sys_rst || mst_oe) prst_q <= 1'b0;
    else if (mst_q && low_c_q >= 16'(swc_pkg::OD_RESET_CYC)) prst_q <= 1'b1;

  property p_zero_in_low;
    ($rose(dev_oe) && !prst_q) |-> mst_oe;
  endproperty
  a_zero_in_low: assert property (p_zero_in_low) else $error("device pull began late");

  property p_zero_bounded;
    (dev_oe && !prst_q) |-> dlow_c_q <= 16'(swc_pkg::OD_SAMPLE_CYC);
  endproperty
  a_zero_bounded: assert property (p_zero_bounded) else $error("device pull too long");

  property p_inside_slot;
    (dev_oe && !prst_q) |-> per_c_q <= 16'(swc_pkg::OD_READ_LOW_CYC + swc_pkg::OD_SAMPLE_CYC);
  endproperty
  a_inside_slot: assert property (p_inside_slot) else $error("device pull outside slot");

  property p_free_at_slot;
    $rose(mst_oe) |-> !dev_oe;
  endproperty
  a_free_at_slot: assert property (p_free_at_slot) else $error("device held line at slot");

  property p_reset_presence;
    ($fell(mst_oe) && low_c_q >= 16'(swc_pkg::OD_RESET_CYC)) |-> ##[1:1000] dev_oe;
  endproperty
  a_reset_presence: assert property (p_reset_presence) else $error("no presence pulse");

  property p_presence_len;
    ($rose(dev_oe) && prst_q) |-> dev_oe [*8];
  endproperty
  a_presence_len: assert property (p_presence_len) else $error("presence pulse short");

  property p_master_low;
    $rose(mst_oe) |-> mst_oe [*8];
  endproperty
  a_master_low: assert property (p_master_low) else $error("master low phase short");

  property p_slot_gap;
    $rose(mst_oe) |-> per_c_q >= 16'(swc_pkg::OD_SLOT_CYC - 1);
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("slots too close");

  // main scenarios
  c_zero_bit: cover property ($rose(dev_oe) && !prst_q);
  c_presence: cover property ($rose(dev_oe) && prst_q);
  c_dev_only: cover property (!line && !mst_oe);
endmodule : swc_link_monitor

// >>> verif/single_wire_crc_and_read_slot_bench.sv
// Purpose: drives the master end against the device end and checks bytes and checks
// Assumes: overdrive timing on both ends, two-byte memory pages
// Notes:   memory is modelled as address xor 3c
`timescale 1ns/10ps
module single_wire_crc_and_read_slot_bench;
  logic        clk = 1'b0;
  logic        sys_rst;
  logic        req;
  logic [1:0]  op;
  logic [7:0]  wdata;
  logic        overdrive;
  logic [7:0]  mem_rdata;
  logic        pw_ok;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic        presence;
  logic [15:0] mem_addr;
  logic        copy_done;
  logic [47:0] id_serial;
  logic [7:0]  id_crc;
  logic [15:0] crc_acc;
  int          err_total = 0;
  int          compares = 0;

  swc_link_if swc_link_if_inst ();

  swc_master swc_master_inst (
    .clk(clk), .sys_rst(sys_rst), .link(swc_link_if_inst), .req(req), .op(op),
    .wdata(wdata), .overdrive(overdrive), .busy_q(busy), .done_q(done),
    .rdata_q(rdata), .presence_q(presence)
  );

  swc_device #(.PAGE_BYTES(2)) swc_device_inst (
    .clk(clk), .sys_rst(sys_rst), .link(swc_link_if_inst), .overdrive(overdrive),
    .mem_rdata(mem_rdata), .pw_ok(pw_ok), .mem_addr_q(mem_addr),
    .copy_done_q(copy_done), .id_serial_q(id_serial), .id_crc_q(id_crc)
  );

  swc_link_monitor swc_link_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .mst_oe(swc_link_if_inst.mst_oe),
    .dev_oe(swc_link_if_inst.dev_oe), .line(swc_link_if_inst.line)
  );

  // clock and memory model
  always #20 clk = ~clk;
  always @(negedge clk) mem_rdata <= mem_addr[7:0] ^ 8'h3c;

  // lsb-first check update; an 8-bit check uses the low byte only
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b,
                                          input logic [15:0] poly);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ poly) : (r >> 1);
    return r;
  endfunction : crc_upd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one request to the master, waits for its done pulse
  task automatic xfer(input logic [1:0] o, input logic [7:0] d);
    int n;
    @(negedge clk);
    req = 1'b1;
    op = o;
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, busy}, 16'h0000);
    if (n >= 20000) chk(16'h0dea, 16'h0000);
  endtask : xfer

  task automatic bus_reset();
    xfer(2'h0, 8'h00);
    chk({15'h0000, presence}, 16'h0001);
    crc_acc = 16'h0000;
  endtask : bus_reset

  task automatic wr(input logic [7:0] d);
    xfer(2'h1, d);
    crc_acc = crc_upd(crc_acc, d, 16'ha001);
  endtask : wr

  task automatic rd(input logic [7:0] e);
    xfer(2'h2, 8'h00);
    chk({8'h00, rdata}, {8'h00, e});
    crc_acc = crc_upd(crc_acc, e, 16'ha001);
  endtask : rd

  // inverted check, low byte then high byte
  task automatic rd_crc();
    logic [15:0] e;
    e = ~crc_acc;
    rd(e[7:0]);
    rd(e[15:8]);
  endtask : rd_crc

  initial
  begin
    logic [15:0] c;
    sys_rst = 1'b1;
    req = 1'b0;
    op = 2'h0;
    wdata = 8'h00;
    overdrive = 1'b1;
    pw_ok = 1'b0;
    crc_acc = 16'h0000;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    // scratch write ending at offset 1f, then a fill byte
    bus_reset();
    c = crc_upd(16'h0000, swc_pkg::ID_FAMILY, 16'h008c);
    for (int i = 0; i < 6; i++)
      c = crc_upd(c, id_serial[8*i +: 8], 16'h008c);
    chk({8'h00, id_crc}, c);
    wr(swc_pkg::CMD_WRITE_SCRATCH);
    wr(8'h1f);
    wr(8'h00);
    wr(8'h5c);
    rd_crc();
    rd(8'hff);
    // scratch read from offset 1f through the end
    bus_reset();
    wr(swc_pkg::CMD_READ_SCRATCH);
    wr(8'h1f);
    wr(8'h00);
    rd(8'h9f);
    rd(8'h5c);
    rd_crc();
    // memory read across a page end, eight password bytes left out
    pw_ok = 1'b1;
    bus_reset();
    wr(swc_pkg::READ_MEMORY_CHECKED_CMD);
    wr(8'h01);
    wr(8'h00);
    repeat (8) xfer(2'h1, 8'hff);
    rd(8'h3d);
    rd_crc();
    crc_acc = 16'h0000;
    rd(8'h3e);
    rd(8'h3f);
    rd_crc();
    // protected copy with matching address and status
    bus_reset();
    wr(swc_pkg::COPY_SCRATCH_PROTECTED_CMD);
    wr(8'h1f);
    wr(8'h00);
    wr(8'h9f);
    repeat (8) xfer(2'h1, 8'hff);
    rd(8'haa);
    chk({15'h0000, copy_done}, 16'h0001);
    wrap_up();
  end

  // watchdog sized from about 45 bytes of overdrive slots plus resets
  initial
  begin
    repeat (110000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : single_wire_crc_and_read_slot_bench
